//--- swrc_pkg.sv
// Shared constants and types of the sleep, wake and reset controller.
// Assumes a single 40 MHz clock; all timing counts except RST_STRETCH_CYC derive from it here.
package swrc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 40;
  localparam int WAKE_MAX_US     = 1700;
  localparam int FORCE_MIN_MS    = 245;
  localparam int RST_MIN_US      = 160;
  localparam int CONV_MS         = 35;
  // Longest times round down, least times round up; all are whole here.
  localparam int WAKE_CYC        = WAKE_MAX_US * CLK_MHZ;
  localparam int FORCE_CYC       = FORCE_MIN_MS * 1000 * CLK_MHZ;
  localparam int RST_CYC         = RST_MIN_US * CLK_MHZ;
  localparam int CONV_CYC        = CONV_MS * 1000 * CLK_MHZ;
  localparam int RST_STRETCH_CYC = 16;
  localparam int CNT_W           = 24;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int MEAS_W     = 14;
  localparam int N_WAKE_SNS = 4;
  localparam int N_SWITCH   = 4;
  localparam int EVT_W      = 3;
  localparam int EVT_SWITCH = 0;
  localparam int EVT_MOTION = 1;
  localparam int EVT_WINDOW = 2;
  localparam logic [13:0] MEAS_RESULT_RST = 14'h0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PWR_AWAKE, PWR_DOZE, PWR_SLEEP, PWR_WAKING} swrc_pwr_e;
  typedef enum logic [2:0] {CAUSE_POR, CAUSE_EXT, CAUSE_SW, CAUSE_BOD,
                            CAUSE_FORCE, CAUSE_SENSOR, CAUSE_FW} swrc_cause_e;

endpackage

//--- swrc_hold_qual.sv
// Pin synchroniser with a minimum-hold qualifier.
// Assumes pin_i is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module swrc_hold_qual #(
  parameter int   HOLD   = 1,
  parameter logic ACTIVE = 1'b1
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic pin_i,
  output var  logic active_o,
  output var  logic qual_o
);

  localparam int CW = $clog2(HOLD + 1);

  logic          meta_q;
  logic [CW-1:0] cnt_q;

  initial
  begin
    if (HOLD < 1 || HOLD >= (1 << swrc_pkg::CNT_W))
      $error("swrc_hold_qual: HOLD out of range");
  end

  // Only the second stage looks at the first.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q   <= ~ACTIVE;
      active_o <= 1'b0;
    end
    else
    begin
      meta_q   <= pin_i;
      active_o <= (meta_q == ACTIVE);
    end
  end

  // Counts consecutive active cycles; a single inactive cycle restarts it.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q  <= '0;
      qual_o <= 1'b0;
    end
    else if (!active_o)
    begin
      cnt_q  <= '0;
      qual_o <= 1'b0;
    end
    else if (cnt_q != CW'(HOLD))
    begin
      cnt_q  <= cnt_q + CW'(1);
      qual_o <= (cnt_q == CW'(HOLD - 1));
    end
  end

endmodule // swrc_hold_qual
`default_nettype wire

//--- swrc_top.sv
// Sleep, doze and wake control, reset gathering, sensor event flags and
// sample measurement unit timing of a wireless module.
// Assumes rstn is the power-on reset; pins arrive asynchronously; firmware
// strobes and the converter sample are on mclk.
// Operation
// - After a valid wake reason in sleep the processor is active within 1.7 ms.
// - A doze state separate from sleep returns to awake at once, with no wake delay.
// - Forced-wake held for at least 245 ms wakes the device from sleep or doze.
// - While forced-wake stays asserted the device enters neither sleep nor doze.
// - Sensor inputs zero to three can wake the device from sleep.
// - Switch, motion and pulsed comparator sensing work both awake and asleep.
// - The sample measurement unit runs only while awake.
// - Switch changes, motion and a level leaving its window are flagged.
// - The measurement unit gives 14-bit results after 35 ms per conversion.
// - Applying power produces a full reset by itself.
// - Pulling the reset pin low from outside for at least 160 us gives a full power-on style reset.
// - A software reset command gives a full power-on style reset.
// - Brown-out holds the device in reset while the supply is too low.
`timescale 1ns/1ps
`default_nettype none
module swrc_top #(
  parameter int WAKE_CYCLES  = swrc_pkg::WAKE_CYC,
  parameter int FORCE_CYCLES = swrc_pkg::FORCE_CYC,
  parameter int RST_CYCLES   = swrc_pkg::RST_CYC,
  parameter int CONV_CYCLES  = swrc_pkg::CONV_CYC
) (
  input  wire logic                            mclk,
  input  wire logic                            rstn,
  input  wire logic                            reset_pin_n,
  input  wire logic                            force_wake_pin,
  input  wire logic                            brownout_pin,
  input  wire logic                            sw_reset_cmd,
  input  wire logic                            sleep_req,
  input  wire logic                            doze_req,
  input  wire logic                            doze_exit_req,
  input  wire logic [swrc_pkg::N_WAKE_SNS-1:0] wake_sensor_pin,
  input  wire logic [swrc_pkg::N_WAKE_SNS-1:0] wake_sensor_en,
  input  wire logic [swrc_pkg::N_SWITCH-1:0]   switch_pin,
  input  wire logic                            motion_pin,
  input  wire logic                            level_outside_pin,
  input  wire logic [swrc_pkg::EVT_W-1:0]      event_clr,
  input  wire logic                            meas_start,
  input  wire logic [swrc_pkg::MEAS_W-1:0]     meas_sample,
  output var  logic                            core_reset_n,
  output var  swrc_pkg::swrc_pwr_e             pwr_state,
  output var  swrc_pkg::swrc_cause_e           wake_cause,
  output var  logic [swrc_pkg::EVT_W-1:0]      sensor_events,
  output var  logic                            meas_busy,
  output var  logic                            meas_done,
  output var  logic [swrc_pkg::MEAS_W-1:0]     meas_result
);

  localparam int CW = swrc_pkg::CNT_W;
  localparam int NS = swrc_pkg::N_WAKE_SNS + swrc_pkg::N_SWITCH + 2;

  initial
  begin
    if (WAKE_CYCLES < 2 || FORCE_CYCLES < 1 || RST_CYCLES < 1 || CONV_CYCLES < 1 ||
        WAKE_CYCLES >= (1 << CW) || CONV_CYCLES >= (1 << CW))
      $error("swrc_top: timing parameter out of range");
  end

  // ---------------------------------------------------------------
  // Pin qualification
  // ---------------------------------------------------------------
  logic ext_qual;
  logic force_lvl;
  logic force_qual;
  logic bod_lvl;

  swrc_hold_qual #(.HOLD(RST_CYCLES), .ACTIVE(1'b0)) u_rst_pin (
    .mclk     (mclk),
    .rstn     (rstn),
    .pin_i    (reset_pin_n),
    .active_o (),
    .qual_o   (ext_qual)
  );

  swrc_hold_qual #(.HOLD(FORCE_CYCLES), .ACTIVE(1'b1)) u_force_pin (
    .mclk     (mclk),
    .rstn     (rstn),
    .pin_i    (force_wake_pin),
    .active_o (force_lvl),
    .qual_o   (force_qual)
  );

  swrc_hold_qual #(.HOLD(1), .ACTIVE(1'b1)) u_bod_pin (
    .mclk     (mclk),
    .rstn     (rstn),
    .pin_i    (brownout_pin),
    .active_o (bod_lvl),
    .qual_o   ()
  );

  logic [NS-1:0] sns_meta_q;
  logic [NS-1:0] sns_sync_q;
  logic [NS-1:0] sns_prev_q;

  // Sensor sensing has no dependency on the power state.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sns_meta_q <= '0;
      sns_sync_q <= '0;
      sns_prev_q <= '0;
    end
    else
    begin
      sns_meta_q <= {level_outside_pin, motion_pin, switch_pin, wake_sensor_pin};
      sns_sync_q <= sns_meta_q;
      sns_prev_q <= sns_sync_q;
    end
  end

  logic [swrc_pkg::N_WAKE_SNS-1:0] wake_sns;
  logic [swrc_pkg::N_SWITCH-1:0]   sw_now;
  logic [swrc_pkg::N_SWITCH-1:0]   sw_old;
  logic                            sens_wake;
  logic                            rst_src;
  logic [swrc_pkg::EVT_W-1:0]      evt_set;

  assign wake_sns  = sns_sync_q[swrc_pkg::N_WAKE_SNS-1:0];
  assign sw_now    = sns_sync_q[swrc_pkg::N_WAKE_SNS +: swrc_pkg::N_SWITCH];
  assign sw_old    = sns_prev_q[swrc_pkg::N_WAKE_SNS +: swrc_pkg::N_SWITCH];
  assign sens_wake = |(wake_sns & wake_sensor_en);
  assign rst_src   = bod_lvl | ext_qual | sw_reset_cmd;
  assign evt_set[swrc_pkg::EVT_SWITCH] = |(sw_now ^ sw_old);
  assign evt_set[swrc_pkg::EVT_MOTION] = sns_sync_q[NS-2] & ~sns_prev_q[NS-2];
  assign evt_set[swrc_pkg::EVT_WINDOW] = sns_sync_q[NS-1] & ~sns_prev_q[NS-1];

  // ---------------------------------------------------------------
  // Reset gathering
  // ---------------------------------------------------------------
  logic [4:0] stretch_q;

  // A short stretch after every source lets all logic settle together.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stretch_q    <= 5'(swrc_pkg::RST_STRETCH_CYC);
      core_reset_n <= 1'b0;
    end
    else if (rst_src)
    begin
      stretch_q    <= 5'(swrc_pkg::RST_STRETCH_CYC);
      core_reset_n <= 1'b0;
    end
    else
    begin
      if (stretch_q != 5'd0)
        stretch_q <= stretch_q - 5'd1;
      core_reset_n <= (stretch_q == 5'd0);
    end
  end

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  logic [CW-1:0] wake_cnt_q;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pwr_state <= swrc_pkg::PWR_AWAKE;
    else if (rst_src)
      pwr_state <= swrc_pkg::PWR_AWAKE;
    else
    begin
      case (pwr_state)
        swrc_pkg::PWR_AWAKE:
        begin
          if (sleep_req && !force_lvl)
            pwr_state <= swrc_pkg::PWR_SLEEP;
          else if (doze_req && !force_lvl)
            pwr_state <= swrc_pkg::PWR_DOZE;
        end
        swrc_pkg::PWR_DOZE:
        begin
          if (force_qual || sens_wake || doze_exit_req)
            pwr_state <= swrc_pkg::PWR_AWAKE;
        end
        swrc_pkg::PWR_SLEEP:
        begin
          if (force_qual || sens_wake)
            pwr_state <= swrc_pkg::PWR_WAKING;
        end
        default:
        begin
          if (wake_cnt_q == CW'(WAKE_CYCLES - 2))
            pwr_state <= swrc_pkg::PWR_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wake_cnt_q <= '0;
    else if (pwr_state == swrc_pkg::PWR_WAKING && !rst_src)
      wake_cnt_q <= wake_cnt_q + CW'(1);
    else
      wake_cnt_q <= '0;
  end

  // ---------------------------------------------------------------
  // Wake and reset cause
  // ---------------------------------------------------------------
  logic asleep;

  assign asleep = (pwr_state == swrc_pkg::PWR_SLEEP) || (pwr_state == swrc_pkg::PWR_DOZE);

  // Survives every reset except power-on, so firmware can read it afterwards.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wake_cause <= swrc_pkg::CAUSE_POR;
    else if (bod_lvl)
      wake_cause <= swrc_pkg::CAUSE_BOD;
    else if (ext_qual)
      wake_cause <= swrc_pkg::CAUSE_EXT;
    else if (sw_reset_cmd)
      wake_cause <= swrc_pkg::CAUSE_SW;
    else if (asleep && force_qual)
      wake_cause <= swrc_pkg::CAUSE_FORCE;
    else if (asleep && sens_wake)
      wake_cause <= swrc_pkg::CAUSE_SENSOR;
    else if (pwr_state == swrc_pkg::PWR_DOZE && doze_exit_req)
      wake_cause <= swrc_pkg::CAUSE_FW;
  end

  // ---------------------------------------------------------------
  // Sensor events
  // ---------------------------------------------------------------
  // A new event in the clearing cycle stays set.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sensor_events <= '0;
    else if (rst_src)
      sensor_events <= '0;
    else
      sensor_events <= (sensor_events & ~event_clr) | evt_set;
  end

  // ---------------------------------------------------------------
  // Sample measurement unit timing
  // ---------------------------------------------------------------
  logic [CW-1:0] conv_cnt_q;

  // Leaving awake aborts a conversion; no result is then delivered.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meas_busy   <= 1'b0;
      meas_done   <= 1'b0;
      conv_cnt_q  <= '0;
      meas_result <= swrc_pkg::MEAS_RESULT_RST;
    end
    else if (rst_src)
    begin
      meas_busy   <= 1'b0;
      meas_done   <= 1'b0;
      conv_cnt_q  <= '0;
      meas_result <= swrc_pkg::MEAS_RESULT_RST;
    end
    else
    begin
      meas_done <= 1'b0;
      if (meas_busy)
      begin
        if (pwr_state != swrc_pkg::PWR_AWAKE)
          meas_busy <= 1'b0;
        else if (conv_cnt_q == CW'(CONV_CYCLES - 1))
        begin
          meas_busy   <= 1'b0;
          meas_done   <= 1'b1;
          meas_result <= meas_sample;
        end
        else
          conv_cnt_q <= conv_cnt_q + CW'(1);
      end
      else if (meas_start && pwr_state == swrc_pkg::PWR_AWAKE)
      begin
        meas_busy  <= 1'b1;
        conv_cnt_q <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_sw_reset;
    sw_reset_cmd && !bod_lvl && !ext_qual;
  endsequence
  sequence s_held_reset;
    !core_reset_n [*2];
  endsequence

  a_no_sleep_forced: assert property ((pwr_state == swrc_pkg::PWR_AWAKE && force_lvl) |=> !asleep)
    else $error("entered sleep or doze while forced awake");
  a_doze_instant: assert property (
    (pwr_state == swrc_pkg::PWR_DOZE && (force_qual || sens_wake) && !rst_src) |=> pwr_state == swrc_pkg::PWR_AWAKE)
    else $error("doze did not return to awake at once");
  a_sensor_wakes: assert property (
    (pwr_state == swrc_pkg::PWR_SLEEP && sens_wake && !rst_src) |=> pwr_state == swrc_pkg::PWR_WAKING)
    else $error("enabled sensor did not start wake");
  a_wake_bound: assert property ((pwr_state == swrc_pkg::PWR_WAKING) |-> (wake_cnt_q <= CW'(WAKE_CYCLES - 2)))
    else $error("wake took longer than allowed");
  a_wake_finish: assert property (
    (pwr_state == swrc_pkg::PWR_WAKING && wake_cnt_q == CW'(WAKE_CYCLES - 2) && !rst_src)
      |=> pwr_state == swrc_pkg::PWR_AWAKE)
    else $error("wake did not complete on time");
  a_meas_awake_only: assert property (
    (meas_busy && pwr_state != swrc_pkg::PWR_AWAKE) |=> !meas_busy && !meas_done)
    else $error("converter ran outside awake");
  a_conv_time: assert property (meas_done |-> $past(conv_cnt_q) == CW'(CONV_CYCLES - 1) && $past(meas_busy))
    else $error("conversion finished at the wrong time");
  a_sw_reset_seq: assert property (s_sw_reset |=> s_held_reset ##0 wake_cause == swrc_pkg::CAUSE_SW)
    else $error("software reset not applied");
  a_bod_hold: assert property (bod_lvl |=> !core_reset_n && wake_cause == swrc_pkg::CAUSE_BOD)
    else $error("brown-out did not hold reset");
  a_ext_reset: assert property (ext_qual && !bod_lvl |=> !core_reset_n && wake_cause == swrc_pkg::CAUSE_EXT)
    else $error("external reset not applied");
  a_motion_flag: assert property (
    (evt_set[swrc_pkg::EVT_MOTION] && !rst_src) |=> sensor_events[swrc_pkg::EVT_MOTION])
    else $error("motion event lost");

endmodule // swrc_top
`default_nettype wire

//--- swrc_host_model.sv
// Host-side partner model: drives the reset, force-wake, brown-out and sensor pins.
// Assumes the testbench calls its tasks from a single process timed by mclk.
`timescale 1ns/1ps
`default_nettype none
module swrc_host_model (
  input  wire logic                            mclk,
  output var  logic                            reset_pin_n,
  output var  logic                            force_wake_pin,
  output var  logic                            brownout_pin,
  output var  logic [swrc_pkg::N_WAKE_SNS-1:0] wake_sensor_pin,
  output var  logic [swrc_pkg::N_SWITCH-1:0]   switch_pin,
  output var  logic                            motion_pin,
  output var  logic                            level_outside_pin
);
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  // Released pins rest at their pull levels: reset high, force-wake low.
  initial
  begin
    reset_pin_n       = 1'b1;
    force_wake_pin    = 1'b0;
    brownout_pin      = 1'b0;
    wake_sensor_pin   = '0;
    switch_pin        = '0;
    motion_pin        = 1'b0;
    level_outside_pin = 1'b0;
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // The low time is the caller's choice so that a too-short pulse can be commanded.
  task automatic reset_pulse(input int n);
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge mclk);
    reset_pin_n <= 1'b1;
  endtask

  // Pin codes: 0 force, 1 brown-out, 2 motion, 3 level, 4-7 wake sensors, 8-11 switches.
  task automatic set_pin(input int id, input logic v);
    @(posedge mclk);
    case (id)
      0: force_wake_pin <= v;
      1: brownout_pin <= v;
      2: motion_pin <= v;
      3: level_outside_pin <= v;
      default:
        if (id < 8) wake_sensor_pin[id-4] <= v;
        else switch_pin[id-8] <= v;
    endcase
  endtask
endmodule // swrc_host_model
`default_nettype wire

//--- swrc_top_tb.sv
// Self-checking testbench of the sleep, wake and reset controller.
// Assumes shortened timing parameters; the host model drives every pin.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module swrc_top_tb;
  localparam int WAKE = 8;
  localparam int FORCE = 10;
  localparam int RST = 5;
  localparam int CONV = 12;
  logic                  mclk;
  logic                  rstn;
  logic                  reset_pin_n;
  logic                  force_wake_pin;
  logic                  brownout_pin;
  logic                  sw_reset_cmd;
  logic                  sleep_req;
  logic                  doze_req;
  logic                  doze_exit_req;
  logic [3:0]            wake_sensor_pin;
  logic [3:0]            wake_sensor_en;
  logic [3:0]            switch_pin;
  logic                  motion_pin;
  logic                  level_outside_pin;
  logic [2:0]            event_clr;
  logic                  meas_start;
  logic [13:0]           meas_sample;
  logic                  core_reset_n;
  swrc_pkg::swrc_pwr_e   pwr_state;
  swrc_pkg::swrc_cause_e wake_cause;
  logic [2:0]            sensor_events;
  logic                  meas_busy;
  logic                  meas_done;
  logic [13:0]           meas_result;
  int                    num_errors = 0;
  int                    cmp_count = 0;

  swrc_top #(.WAKE_CYCLES(WAKE), .FORCE_CYCLES(FORCE), .RST_CYCLES(RST), .CONV_CYCLES(CONV)) DUT (
    .mclk(mclk), .rstn(rstn), .reset_pin_n(reset_pin_n), .force_wake_pin(force_wake_pin),
    .brownout_pin(brownout_pin), .sw_reset_cmd(sw_reset_cmd), .sleep_req(sleep_req),
    .doze_req(doze_req), .doze_exit_req(doze_exit_req), .wake_sensor_pin(wake_sensor_pin),
    .wake_sensor_en(wake_sensor_en), .switch_pin(switch_pin), .motion_pin(motion_pin),
    .level_outside_pin(level_outside_pin), .event_clr(event_clr), .meas_start(meas_start),
    .meas_sample(meas_sample), .core_reset_n(core_reset_n), .pwr_state(pwr_state),
    .wake_cause(wake_cause), .sensor_events(sensor_events), .meas_busy(meas_busy),
    .meas_done(meas_done), .meas_result(meas_result));

  swrc_host_model host (
    .mclk(mclk), .reset_pin_n(reset_pin_n), .force_wake_pin(force_wake_pin),
    .brownout_pin(brownout_pin), .wake_sensor_pin(wake_sensor_pin), .switch_pin(switch_pin),
    .motion_pin(motion_pin), .level_outside_pin(level_outside_pin));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Codes: 0 sleep, 1 doze, 2 doze exit, 3 software reset, 4 converter start.
  task automatic req(input int k);
    @(posedge mclk);
    case (k)
      0: sleep_req <= 1'b1;
      1: doze_req <= 1'b1;
      2: doze_exit_req <= 1'b1;
      3: sw_reset_cmd <= 1'b1;
      default: meas_start <= 1'b1;
    endcase
    @(posedge mclk);
    {sleep_req, doze_req, doze_exit_req, sw_reset_cmd, meas_start} <= 5'h00;
  endtask

  task automatic wait_pwr(input swrc_pkg::swrc_pwr_e s, input int lim, output int n);
    n = 0;
    while (pwr_state !== s && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (pwr_state !== s)
    begin
      `CHK("pwr_state", s, pwr_state)
      end_of_test();
    end
  endtask

  task automatic wait_up(input int lim, output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (core_reset_n !== 1'b1)
    begin
      `CHK("core_reset_n", 1'b1, core_reset_n)
      end_of_test();
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_por();
    int n;
    wait_up(40, n);
    `CHK("por_release_edges", 17, n)
    `CHK("por_cause", swrc_pkg::CAUSE_POR, wake_cause)
    `CHK("por_events", 3'h0, sensor_events)
  endtask

  task automatic t_sensor();
    int n;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      wake_sensor_en <= 4'h1 << i;
      req(0);
      wait_pwr(swrc_pkg::PWR_SLEEP, 4, n);
      host.set_pin(4 + ((i + 1) % 4), 1'b1);
      cyc(12);
      `CHK("disabled_sensor", swrc_pkg::PWR_SLEEP, pwr_state)
      host.set_pin(4 + ((i + 1) % 4), 1'b0);
      host.set_pin(4 + i, 1'b1);
      wait_pwr(swrc_pkg::PWR_AWAKE, WAKE + 6, n);
      `CHK("wake_latency", 1'b1, n <= WAKE + 2)
      `CHK("sensor_cause", swrc_pkg::CAUSE_SENSOR, wake_cause)
      host.set_pin(4 + i, 1'b0);
    end
  endtask

  task automatic t_doze();
    int n;
    req(1);
    wait_pwr(swrc_pkg::PWR_DOZE, 4, n);
    req(4);
    cyc(2);
    `CHK("meas_in_doze", 1'b0, meas_busy)
    req(2);
    wait_pwr(swrc_pkg::PWR_AWAKE, 2, n);
    `CHK("doze_exit_fast", 1'b1, n <= 1)
    `CHK("doze_cause", swrc_pkg::CAUSE_FW, wake_cause)
  endtask

  task automatic t_meas();
    int   n;
    logic seen;
    @(posedge mclk);
    meas_sample <= 14'h3a5c;
    req(4);
    n = 0;
    while (meas_done !== 1'b1 && n < CONV + 4)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK("meas_time", 1'b1, n >= CONV && n <= CONV + 2)
    `CHK("meas_result", 14'h3a5c, meas_result)
    if (meas_done !== 1'b1)
      end_of_test();
    // Leaving the awake state mid-conversion must abort it silently.
    req(4);
    cyc(3);
    req(1);
    seen = 1'b0;
    repeat (CONV + 4)
    begin
      @(posedge mclk);
      #1;
      seen = seen | meas_done;
    end
    `CHK("meas_abort", 1'b0, seen)
    req(2);
    wait_pwr(swrc_pkg::PWR_AWAKE, 2, n);
  endtask

  task automatic t_events();
    int n;
    @(posedge mclk);
    wake_sensor_en <= 4'h0;
    req(0);
    wait_pwr(swrc_pkg::PWR_SLEEP, 4, n);
    host.set_pin(10, 1'b1);
    host.set_pin(2, 1'b1);
    host.set_pin(3, 1'b1);
    cyc(5);
    `CHK("events_rise", 3'h7, sensor_events)
    @(posedge mclk);
    event_clr <= 3'h7;
    @(posedge mclk);
    event_clr <= 3'h0;
    cyc(1);
    `CHK("events_clear", 3'h0, sensor_events)
    host.set_pin(10, 1'b0);
    host.set_pin(2, 1'b0);
    host.set_pin(3, 1'b0);
    cyc(5);
    `CHK("switch_open", 3'h1, sensor_events)
  endtask

  task automatic t_force();
    int n;
    host.set_pin(0, 1'b1);
    cyc(4);
    host.set_pin(0, 1'b0);
    cyc(20);
    `CHK("short_force", swrc_pkg::PWR_SLEEP, pwr_state)
    host.set_pin(0, 1'b1);
    wait_pwr(swrc_pkg::PWR_AWAKE, FORCE + WAKE + 6, n);
    `CHK("force_cause", swrc_pkg::CAUSE_FORCE, wake_cause)
    req(0);
    req(1);
    cyc(2);
    `CHK("force_blocks", swrc_pkg::PWR_AWAKE, pwr_state)
    host.set_pin(0, 1'b0);
    cyc(4);
    req(1);
    wait_pwr(swrc_pkg::PWR_DOZE, 4, n);
    host.set_pin(0, 1'b1);
    wait_pwr(swrc_pkg::PWR_AWAKE, FORCE + 6, n);
    host.set_pin(0, 1'b0);
    cyc(4);
  endtask

  task automatic t_resets();
    int n;
    host.set_pin(1, 1'b1);
    cyc(4);
    `CHK("bod_low", 1'b0, core_reset_n)
    cyc(20);
    `CHK("bod_hold", 1'b0, core_reset_n)
    `CHK("bod_cause", swrc_pkg::CAUSE_BOD, wake_cause)
    host.set_pin(1, 1'b0);
    wait_up(30, n);
    host.reset_pulse(RST - 2);
    cyc(4);
    `CHK("ext_short", 1'b1, core_reset_n)
    host.reset_pulse(RST + 4);
    cyc(1);
    `CHK("ext_low", 1'b0, core_reset_n)
    `CHK("ext_cause", swrc_pkg::CAUSE_EXT, wake_cause)
    wait_up(30, n);
    req(1);
    wait_pwr(swrc_pkg::PWR_DOZE, 4, n);
    req(3);
    cyc(2);
    `CHK("sw_low", 1'b0, core_reset_n)
    `CHK("sw_pwr", swrc_pkg::PWR_AWAKE, pwr_state)
    `CHK("sw_cause", swrc_pkg::CAUSE_SW, wake_cause)
    wait_up(30, n);
    `CHK("sw_release", 1'b1, core_reset_n)
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    {sw_reset_cmd, sleep_req, doze_req, doze_exit_req, meas_start} = 5'h00;
    wake_sensor_en = 4'h0;
    event_clr = 3'h0;
    meas_sample = 14'h0000;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_por();
    t_sensor();
    t_doze();
    t_meas();
    t_events();
    t_force();
    t_resets();
    end_of_test();
  end
endmodule // swrc_top_tb
`default_nettype wire
